/* File: hw/wdx_pkg.sv */
/*
  constants, register map and carrier types of the waveform dead-time and
  fault register block.
  assumes a single 40 mhz peripheral clock and an axi4-lite register bus.
*/
// Operation
// - fault action 00 means no action; codes 01 and 10 are reserved
// - fault action 11 clears direction bits of enabled dead-time channels on fault
// - fault flag in status bit 2 sets on any masked event channel; the code sets it only while fault action is not 00
// - fault flag clears only when software writes one to it
// - valid buffer moves into working register at next update only
// - buffer transfer is held off while the timer lock-update flag is set
// - both-sides write loads low and high dead-time registers together
// - both-sides buffer write loads low and high buffers together
// - low-side dead-time register holds an 8-bit cycle count
// - high-side dead-time register holds an 8-bit cycle count
// - valid low-side buffer copies into low-side register on update
// - valid high-side buffer copies into high-side register on update
// - override enable register accepts writes only while fault flag is zero
// - each override enable bit overrides the port output bit of its pin
// - override acts on output value only, never on pin direction
// - masked fault inputs of all event channels are ored together
// - fault action starts at most two clock cycles after the event
// - latched mode needs flag clear and fault gone; cycle mode fault gone; then update
// - leaving fault restores direction bits cleared by the fault action
package wdx_pkg;

  // ==========================================================================
  // register word indices, matched against address bits 5:2
  localparam logic [3:0] WDX_OFS_CTRL = 4'h0;
  localparam logic [3:0] WDX_OFS_FMASK = 4'h2;
  localparam logic [3:0] WDX_OFS_FCTRL = 4'h3;
  localparam logic [3:0] WDX_OFS_STATUS = 4'h4;
  localparam logic [3:0] WDX_OFS_DEAD_TIME_BOTH_SIDES = 4'h6;
  localparam logic [3:0] WDX_OFS_DEAD_TIME_BOTH_BUFFER_WRITE = 4'h7;
  localparam logic [3:0] WDX_OFS_DTLOW = 4'h8;
  localparam logic [3:0] WDX_OFS_DTHIGH = 4'h9;
  localparam logic [3:0] WDX_OFS_DTLOWBUF = 4'ha;
  localparam logic [3:0] WDX_OFS_DTHIGHBUF = 4'hb;
  localparam logic [3:0] WDX_OFS_OVEN = 4'hc;
  localparam int WDX_ADDR_W = 6;

  // ==========================================================================
  // field positions
  localparam int WDX_ST_FAULT_BIT = 2;
  localparam int WDX_ST_HIV_BIT = 1;
  localparam int WDX_ST_LOV_BIT = 0;
  localparam int WDX_FC_MODE_BIT = 2;
  localparam int WDX_FC_DBD_BIT = 4;
  localparam logic [7:0] WDX_CTRL_MASK = 8'h3f;
  localparam logic [7:0] WDX_FCTRL_MASK = 8'h17;
  localparam logic [7:0] WDX_RESET_VAL = 8'h00;

  // ==========================================================================
  // fault action codes and responses
  localparam logic [1:0] WDX_ACT_NONE = 2'h0;
  localparam logic [1:0] WDX_ACT_CLEAR_DIR = 2'h3;
  localparam logic [1:0] WDX_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDX_RESP_SLVERR = 2'h2;

  // port-side output carrier
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] ov_en;
  } wdx_port_t;

endpackage

/* File: hw/wdx_top.sv */
/*
  waveform extension register block: fault protection, dead-time registers
  with double buffers, output override enable, behind an axi4-lite slave.
  assumes synchronous inputs from the timer (update, lock-update), the event
  system and the port direction register, all on i_clk.
*/
// Implementation choice: register access over AXI4-Lite.
module wdx_top #(
  parameter int NCH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [5:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [NCH-1:0] i_events,
  input wire logic i_debug_break,
  input wire logic i_update,
  input wire logic i_timer_lock_update_flag,
  input wire logic [7:0] i_port_dir,
  output wdx_pkg::wdx_port_t o_port,
  output logic o_fault_active,
  output logic [7:0] o_low_side_dead_cycles,
  output logic [7:0] o_high_side_dead_cycles
);

  // ==========================================================================
  // reset synchroniser
  logic rst_q1_r;
  logic rst_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q1_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_r <= rst_q1_r;
    end
  end
  wire rst_n = rst_r;

  // ==========================================================================
  // axi4-lite write channel capture
  logic aw_held_r;
  logic w_held_r;
  logic [5:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic wr_fire;
  assign wr_fire = aw_held_r && w_held_r && !o_bvalid;

  // address and data are taken in either order, response after both
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_held_r && !(i_awvalid && o_awready);
      o_wready <= !w_held_r && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= i_wdata[7:0];
        wstrb0_r <= i_wstrb[0];
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // address decode shared by both channels
  function automatic logic addr_known(input logic [5:0] a);
    logic [3:0] idx;
    idx = a[5:2];
    addr_known = (a[1:0] == 2'h0) && (idx != 4'h1) && (idx != 4'h5) && (idx <= 4'hc);
  endfunction

  // write strobe per register, only with byte lane 0 enabled
  logic wr_ok;
  logic [3:0] wr_idx;
  assign wr_ok = wr_fire && wstrb0_r && addr_known(awaddr_r);
  assign wr_idx = awaddr_r[5:2];
  function automatic logic hit(input logic [3:0] ofs, input logic [3:0] idx, input logic en);
    hit = en && (idx == ofs);
  endfunction

  // write response
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp <= wdx_pkg::WDX_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= addr_known(awaddr_r) ? wdx_pkg::WDX_RESP_OKAY : wdx_pkg::WDX_RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration registers
  logic [7:0] ctrl_r;
  logic [NCH-1:0] fault_event_channel_mask_r;
  logic [7:0] fctrl_r;
  logic [1:0] fault_action_select;
  logic fault_restart_mode;
  logic ignore_debug_break_fault;
  assign fault_action_select = fctrl_r[1:0];
  assign fault_restart_mode = fctrl_r[wdx_pkg::WDX_FC_MODE_BIT];
  assign ignore_debug_break_fault = fctrl_r[wdx_pkg::WDX_FC_DBD_BIT];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= wdx_pkg::WDX_RESET_VAL;
      fault_event_channel_mask_r <= '0;
      fctrl_r <= wdx_pkg::WDX_RESET_VAL;
    end else begin
      if (hit(wdx_pkg::WDX_OFS_CTRL, wr_idx, wr_ok)) begin
        ctrl_r <= wdata_r & wdx_pkg::WDX_CTRL_MASK;
      end
      if (hit(wdx_pkg::WDX_OFS_FMASK, wr_idx, wr_ok)) begin
        fault_event_channel_mask_r <= wdata_r[NCH-1:0];
      end
      if (hit(wdx_pkg::WDX_OFS_FCTRL, wr_idx, wr_ok)) begin
        fctrl_r <= wdata_r & wdx_pkg::WDX_FCTRL_MASK;
      end
    end
  end

  // ==========================================================================
  // fault detection
  logic fault_in;
  logic prot_on;
  assign prot_on = (fault_action_select != wdx_pkg::WDX_ACT_NONE);
  assign fault_in = prot_on && ((|(i_events & fault_event_channel_mask_r))
                    || (i_debug_break && !ignore_debug_break_fault));

  logic fault_detected_flag_r;
  logic st_wr;
  assign st_wr = hit(wdx_pkg::WDX_OFS_STATUS, wr_idx, wr_ok);

  // sticky flag, set wins over write-one clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_detected_flag_r <= 1'b0;
    end else if (fault_in) begin
      fault_detected_flag_r <= 1'b1;
    end else if (st_wr && wdata_r[wdx_pkg::WDX_ST_FAULT_BIT]) begin
      fault_detected_flag_r <= 1'b0;
    end
  end

  // fault state: entered the cycle after the event, left at update
  logic fault_state_r;
  logic fault_release;
  assign fault_release = !fault_in && (fault_restart_mode || !fault_detected_flag_r);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_state_r <= 1'b0;
    end else if (fault_in) begin
      fault_state_r <= 1'b1;
    end else if (fault_state_r && fault_release && i_update) begin
      fault_state_r <= 1'b0;
    end
  end

  // ==========================================================================
  // dead-time registers and double buffers
  logic [7:0] low_side_dead_cycles_r;
  logic [7:0] high_side_dead_cycles_r;
  logic [7:0] low_side_dead_buffer_r;
  logic [7:0] high_side_dead_buffer_r;
  logic low_side_buffer_valid_r;
  logic high_side_buffer_valid_r;
  logic xfer_ok;
  logic wr_both;
  logic wr_bboth;
  assign xfer_ok = i_update && !i_timer_lock_update_flag;
  assign wr_both = hit(wdx_pkg::WDX_OFS_DEAD_TIME_BOTH_SIDES, wr_idx, wr_ok);
  assign wr_bboth = hit(wdx_pkg::WDX_OFS_DEAD_TIME_BOTH_BUFFER_WRITE, wr_idx, wr_ok);

  // working registers: direct or both-sides write, else buffer transfer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_side_dead_cycles_r <= wdx_pkg::WDX_RESET_VAL;
      high_side_dead_cycles_r <= wdx_pkg::WDX_RESET_VAL;
    end else begin
      if (wr_both || hit(wdx_pkg::WDX_OFS_DTLOW, wr_idx, wr_ok)) begin
        low_side_dead_cycles_r <= wdata_r;
      end else if (xfer_ok && low_side_buffer_valid_r) begin
        low_side_dead_cycles_r <= low_side_dead_buffer_r;
      end
      if (wr_both || hit(wdx_pkg::WDX_OFS_DTHIGH, wr_idx, wr_ok)) begin
        high_side_dead_cycles_r <= wdata_r;
      end else if (xfer_ok && high_side_buffer_valid_r) begin
        high_side_dead_cycles_r <= high_side_dead_buffer_r;
      end
    end
  end

  // buffers and valid flags; a buffer write beats a same-cycle transfer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_side_dead_buffer_r <= wdx_pkg::WDX_RESET_VAL;
      high_side_dead_buffer_r <= wdx_pkg::WDX_RESET_VAL;
      low_side_buffer_valid_r <= 1'b0;
      high_side_buffer_valid_r <= 1'b0;
    end else begin
      if (wr_bboth || hit(wdx_pkg::WDX_OFS_DTLOWBUF, wr_idx, wr_ok)) begin
        low_side_dead_buffer_r <= wdata_r;
        low_side_buffer_valid_r <= 1'b1;
      end else if (st_wr && wdata_r[wdx_pkg::WDX_ST_LOV_BIT]) begin
        low_side_buffer_valid_r <= 1'b1;
      end else if (xfer_ok) begin
        low_side_buffer_valid_r <= 1'b0;
      end
      if (wr_bboth || hit(wdx_pkg::WDX_OFS_DTHIGHBUF, wr_idx, wr_ok)) begin
        high_side_dead_buffer_r <= wdata_r;
        high_side_buffer_valid_r <= 1'b1;
      end else if (st_wr && wdata_r[wdx_pkg::WDX_ST_HIV_BIT]) begin
        high_side_buffer_valid_r <= 1'b1;
      end else if (xfer_ok) begin
        high_side_buffer_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // output override enable, writes blocked while fault flag is set
  logic [7:0] pin_output_override_mask_r;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_output_override_mask_r <= wdx_pkg::WDX_RESET_VAL;
    end else if (hit(wdx_pkg::WDX_OFS_OVEN, wr_idx, wr_ok) && !fault_detected_flag_r) begin
      pin_output_override_mask_r <= wdata_r;
    end
  end

  // ==========================================================================
  // port outputs: direction masked during fault with action 11, override bits per pin
  logic [7:0] dti_pins;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      dti_pins[2*k] = ctrl_r[k];
      dti_pins[2*k+1] = ctrl_r[k];
    end
  end
  logic clear_dir;
  assign clear_dir = fault_state_r && (fault_action_select == wdx_pkg::WDX_ACT_CLEAR_DIR);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_port <= '0;
      o_fault_active <= 1'b0;
      o_low_side_dead_cycles <= wdx_pkg::WDX_RESET_VAL;
      o_high_side_dead_cycles <= wdx_pkg::WDX_RESET_VAL;
    end else begin
      o_port.dir <= clear_dir ? (i_port_dir & ~dti_pins) : i_port_dir;
      o_port.ov_en <= pin_output_override_mask_r;
      o_fault_active <= fault_state_r;
      o_low_side_dead_cycles <= low_side_dead_cycles_r;
      o_high_side_dead_cycles <= high_side_dead_cycles_r;
    end
  end

  // ==========================================================================
  // read channel
  function automatic logic [7:0] rd_mux(input logic [3:0] idx);
    case (idx)
      wdx_pkg::WDX_OFS_CTRL: rd_mux = ctrl_r;
      wdx_pkg::WDX_OFS_FMASK: rd_mux = 8'(fault_event_channel_mask_r);
      wdx_pkg::WDX_OFS_FCTRL: rd_mux = fctrl_r;
      wdx_pkg::WDX_OFS_STATUS: rd_mux = {5'h00, fault_detected_flag_r,
                                         high_side_buffer_valid_r, low_side_buffer_valid_r};
      wdx_pkg::WDX_OFS_DTLOW: rd_mux = low_side_dead_cycles_r;
      wdx_pkg::WDX_OFS_DTHIGH: rd_mux = high_side_dead_cycles_r;
      wdx_pkg::WDX_OFS_DTLOWBUF: rd_mux = low_side_dead_buffer_r;
      wdx_pkg::WDX_OFS_DTHIGHBUF: rd_mux = high_side_dead_buffer_r;
      wdx_pkg::WDX_OFS_OVEN: rd_mux = pin_output_override_mask_r;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // one read at a time, data one cycle after the address is taken
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= wdx_pkg::WDX_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= {24'h000000, rd_mux(i_araddr[5:2])};
        o_rresp <= addr_known(i_araddr) ? wdx_pkg::WDX_RESP_OKAY : wdx_pkg::WDX_RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: dv/wdx_checker.sv */
/*
  port-level assertions for the waveform dead-time and fault block.
  assumes the partner holds the port direction steady after reset.
*/
module wdx_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic i_update,
  input wire logic i_timer_lock_update_flag,
  input wire logic [7:0] i_port_dir,
  input wire wdx_pkg::wdx_port_t o_port,
  input wire logic o_fault_active,
  input wire logic [7:0] o_low_side_dead_cycles,
  input wire logic [7:0] o_high_side_dead_cycles
);
  // ==========================================================================
  // helpers
  logic [2:0] up_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // cycles since reset release, saturating
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_quiet;
    (up_r == 3'h7) && !o_fault_active [*3];
  endsequence

  // ==========================================================================
  // properties
  // outputs lag the working register by one cycle, the register lags its cause by one
  property p_low_cause;
    $changed(o_low_side_dead_cycles) |->
      $past(o_bvalid) || $past(i_update && !i_timer_lock_update_flag, 2);
  endproperty
  property p_high_cause;
    $changed(o_high_side_dead_cycles) |->
      $past(o_bvalid) || $past(i_update && !i_timer_lock_update_flag, 2);
  endproperty
  property p_both_pair;
    $past(o_bvalid) && $changed(o_low_side_dead_cycles) && $changed(o_high_side_dead_cycles)
      |-> o_low_side_dead_cycles == o_high_side_dead_cycles;
  endproperty
  property p_dir_kept;
    s_quiet |-> o_port.dir == i_port_dir;
  endproperty
  property p_dir_sub;
    (o_port.dir & ~i_port_dir) == 8'h00;
  endproperty
  property p_ov_hold;
    o_fault_active && $past(o_fault_active) |-> $stable(o_port.ov_en);
  endproperty
  property p_wr_resp;
    s_wr_taken |-> ##[1:3] o_bvalid;
  endproperty
  property p_rd_resp;
    i_arvalid && o_arready |=> o_rvalid && o_rdata[31:8] == 24'h000000;
  endproperty

  // ==========================================================================
  // assertions
  a_low_cause: assert property (p_low_cause) else $error("low dead-time changed");
  a_high_cause: assert property (p_high_cause) else $error("high dead-time changed");
  a_both_pair: assert property (p_both_pair) else $error("both-sides mismatch");
  a_dir_kept: assert property (p_dir_kept) else $error("direction not kept");
  a_dir_sub: assert property (p_dir_sub) else $error("direction bit invented");
  a_ov_hold: assert property (p_ov_hold) else $error("override changed in fault");
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
endmodule

bind wdx_top wdx_checker u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_update(i_update),
  .i_timer_lock_update_flag(i_timer_lock_update_flag), .i_port_dir(i_port_dir),
  .o_port(o_port), .o_fault_active(o_fault_active),
  .o_low_side_dead_cycles(o_low_side_dead_cycles),
  .o_high_side_dead_cycles(o_high_side_dead_cycles)
);

/* File: dv/wdx_partner.sv */
/*
  timer and port model: update pulse and lock flag on request, port direction.
  assumes requests from the bench on the rising edge.
*/
module wdx_partner (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_upd_req,
  input wire logic i_lock_req,
  output logic o_update,
  output logic o_lock_flag,
  output logic [7:0] o_port_dir
);
  // ==========================================================================
  // timer side and port direction register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_update <= 1'b0;
      o_lock_flag <= 1'b0;
      o_port_dir <= 8'h00;
    end else begin
      o_update <= i_upd_req;
      o_lock_flag <= i_lock_req;
      o_port_dir <= 8'hff; // all pins outputs
    end
  end
endmodule

/* File: dv/wdx_top_test.sv */
/*
  register-level bench for the waveform dead-time and fault block.
  assumes the partner model stands for the timer and port logic.
*/
module wdx_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] OKR = wdx_pkg::WDX_RESP_OKAY;
  localparam logic [1:0] SER = wdx_pkg::WDX_RESP_SLVERR;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end

  // ==========================================================================
  // signals and instances
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, upd_req, lock, upd, lk;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0] events, pdir, lo, hi;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, fault;
  wdx_pkg::wdx_port_t port;
  int err_count, compares;
  logic [5:0] ra [11] = '{6'h00, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h1c, 6'h20, 6'h24, 6'h28,
    6'h2c, 6'h30};
  wdx_partner u_par (.i_clk(clk), .i_rst_n(rst_n), .i_upd_req(upd_req), .i_lock_req(lock),
    .o_update(upd), .o_lock_flag(lk), .o_port_dir(pdir));
  wdx_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_events(events),
    .i_debug_break(1'b0), .i_update(upd), .i_timer_lock_update_flag(lk), .i_port_dir(pdir),
    .o_port(port), .o_fault_active(fault), .o_low_side_dead_cycles(lo),
    .o_high_side_dead_cycles(hi));

  // ==========================================================================
  // tasks
  task print_verdict;
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task to(input int n);
    if (n >= 50) begin
      err_count++;
      $display("[ERR] %0t no answer", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ad, wd;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    ad = 1'b0; wd = 1'b0; n = 0;
    while (!(ad && wd) && n < 50) begin
      @(posedge clk);
      n++;
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    to(n);
    bready <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 50);
    to(n);
    `CHK(bresp, er)
    bready <= 1'b0;
    // let the written value reach the registered outputs
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; n = 0;
    do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 50);
    to(n);
    arvalid <= 1'b0; rready <= 1'b1; n = 0;
    do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 50);
    to(n);
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask
  // one update pulse through the timer model
  task upd_pulse;
    @(posedge clk); upd_req <= 1'b1;
    @(posedge clk); upd_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one-cycle event, then settle two edges later
  task ev(input logic [7:0] m);
    @(posedge clk); events <= m;
    @(posedge clk); events <= 8'h00;
    @(posedge clk); #1;
  endtask

  // ==========================================================================
  // clock, reset, sequence
  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, upd_req, lock} = '0;
    awaddr = '0; araddr = '0; wdata = '0; events = '0; err_count = 0; compares = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 11; i++) rd(ra[i], 8'h00, OKR);
    wr(6'h04, 8'h55, SER); rd(6'h14, 8'h00, SER);
    wr(6'h18, 8'h5a, OKR); `CHK({lo, hi}, 16'h5a5a)
    rd(6'h24, 8'h5a, OKR);
    wr(6'h1c, 8'h3c, OKR); rd(6'h10, 8'h03, OKR);
    `CHK(lo, 8'h5a)
    lock <= 1'b1; upd_pulse(); `CHK({lo, hi}, 16'h5a5a)
    lock <= 1'b0; upd_pulse(); `CHK({lo, hi}, 16'h3c3c)
    rd(6'h10, 8'h00, OKR);
    wr(6'h28, 8'h11, OKR); upd_pulse(); `CHK({lo, hi}, 16'h113c)
    wr(6'h2c, 8'h22, OKR); upd_pulse(); `CHK({lo, hi}, 16'h1122)
    wr(6'h00, 8'h01, OKR); wr(6'h08, 8'h80, OKR); wr(6'h0c, 8'h03, OKR);
    wr(6'h30, 8'h0f, OKR); `CHK(port.ov_en, 8'h0f)
    ev(8'h08); rd(6'h10, 8'h00, OKR);
    ev(8'h80); `CHK(port.dir, 8'hfc)
    rd(6'h10, 8'h04, OKR);
    wr(6'h30, 8'hf0, OKR); `CHK(port.ov_en, 8'h0f)
    wr(6'h10, 8'h00, OKR); rd(6'h10, 8'h04, OKR);
    upd_pulse(); `CHK(port.dir, 8'hfc)
    wr(6'h10, 8'h04, OKR); rd(6'h10, 8'h00, OKR);
    `CHK(fault, 1'b1)
    upd_pulse(); `CHK({fault, port.dir}, 9'h0ff)
    wr(6'h0c, 8'h07, OKR); ev(8'h80); `CHK(port.dir, 8'hfc)
    upd_pulse(); `CHK(port.dir, 8'hff)
    wr(6'h10, 8'h04, OKR); wr(6'h0c, 8'h00, OKR);
    ev(8'h80); `CHK({fault, port.dir}, 9'h0ff)
    print_verdict();
  end
endmodule
